// ==== rtl/etd_consts.svh ====
`ifndef ETD_CONSTS_SVH
`define ETD_CONSTS_SVH
`define ETD_OFF_MAC_CTRL 8'h00
`define ETD_OFF_TX_CTRL 8'h04
`define ETD_OFF_TEARDOWN 8'h08
`define ETD_OFF_FIFO_CTRL 8'h0c
`define ETD_OFF_SOFT_RESET 8'h10
`define ETD_OFF_MAC_STATUS 8'h14
`define ETD_OFF_TX_PEND 8'h18
`define ETD_OFF_SRC_LOW 8'h1c
`define ETD_OFF_SRC_HIGH 8'h20
`define ETD_OFF_HDP_BASE 8'h40
`define ETD_OFF_CP_BASE 8'h60
`define ETD_BIT_PRI_TYPE 0
`define ETD_BIT_TX_EN 0
`define ETD_BIT_SOFT_RESET 0
`define ETD_TD_CP_VALUE 32'hffff_fffc
`define ETD_TX_CELLS 24
`define ETD_RX_CELLS 68
`define ETD_CELL_BYTES 64
`define ETD_THRESH_RESET 5'h18
`endif

// ==== rtl/etd_pkg.sv ====
package etd_pkg;
   typedef enum logic [1:0] {TD_IDLE, TD_DRAIN, TD_FLAG, TD_FINISH} etd_td_state_type;
endpackage

// ==== rtl/etd_arb.sv ====
`timescale 1ns/100ps
`default_nettype none
// Picks one requesting channel: highest index in fixed mode, or the first
// requester above the last served one, wrapping, in round-robin mode.
module etd_arb #(
   parameter int N = 8
) (
   input wire logic [N-1:0] req,
   input wire logic rr_mode,
   input wire logic [$clog2(N)-1:0] last,
   output logic any,
   output logic [$clog2(N)-1:0] chan
);
   initial begin
      if (N < 2) $error("etd_arb needs at least two channels");
   end
   always_comb begin
      logic [$clog2(N)-1:0] idx;
      logic found;
      idx = '0;
      found = 1'b0;
      chan = '0;
      any = |req;
      if (rr_mode) begin
         for (int k = 1; k <= N; k++) begin
            idx = last + k[$clog2(N)-1:0];
            if (!found && req[idx]) begin
               chan = idx;
               found = 1'b1;
            end
         end
      end else begin
         for (int k = 0; k < N; k++) begin
            if (req[k]) begin
               chan = k[$clog2(N)-1:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/etd_start_gate.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "etd_consts.svh"
// Lets the wire side start once enough cells or the whole packet are queued.
module etd_start_gate #(
   parameter int CELLS = `ETD_TX_CELLS
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [4:0] cells_avail,
   input wire logic pkt_complete,
   input wire logic [4:0] thresh,
   output logic start
);
   initial begin
      if (CELLS < 1 || CELLS > 31) $error("etd_start_gate cell count out of range");
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         start <= 1'b0;
      end else begin
         start <= pkt_complete || (cells_avail >= thresh);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/etd_tx_dma.sv ====
// What this block does
// - One control bit picks fixed or round-robin arbitration over eight queues.
// - Fixed mode serves channel 7 first, channel 0 last.
// - Round-robin rotates upward from channel 0 to 7, then wraps.
// - Host writes a channel number to request teardown; accepted any time.
// - Teardown lets a frame already in flight on that channel finish.
// - Teardown flags the next start-of-packet descriptor when one exists.
// - Teardown clears the channel head descriptor pointer.
// - Teardown completion raises that channel's transmit interrupt.
// - After teardown the completion pointer reads ffff_fffc.
// - Teardown leaves transmit enable untouched.
// - Teardown of an inactive channel still interrupts, sets the pointer, touches no descriptor.
// - Transmit FIFO has 24 cells, receive 68, each 64 bytes.
// - Wire transmission starts at the cell threshold or a complete packet.
// - Threshold accepts up to 24; 24 waits for a whole maximum packet.
// - Writing one to soft-reset bit 0 resets the logic and registers.
// - Soft reset waits until the DMA is idle; software drains frames first.
// - Soft-reset bit reads one while pending, zero when done.
// - Soft reset does not reach management or interrupt-wrapper logic.
// - Host error is cleared only by hardware reset; its code stays readable.
`timescale 1ns/100ps
`default_nettype none
`include "etd_consts.svh"
module etd_tx_dma
   import etd_pkg::*;
#(
   parameter int TX_CELLS = `ETD_TX_CELLS,
   parameter int RX_CELLS = `ETD_RX_CELLS
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic sel_valid,
   output logic [2:0] sel_chan,
   output logic [31:0] sel_ptr,
   input wire logic sel_ready,
   input wire logic frame_busy,
   input wire logic [2:0] frame_chan,
   input wire logic done_valid,
   input wire logic [2:0] done_chan,
   input wire logic [31:0] done_next_ptr,
   input wire logic [31:0] done_cp,
   output logic flag_valid,
   output logic [31:0] flag_ptr,
   input wire logic flag_ready,
   input wire logic [4:0] fifo_cells,
   input wire logic fifo_pkt_complete,
   output logic wire_start,
   input wire logic host_err_valid,
   input wire logic [7:0] host_err_code,
   output logic [7:0] tx_irq,
   output logic host_error_irq,
   output logic mac_sreset,
   output logic tx_enable,
   output logic [47:0] src_mac_addr
);
   // The FIFOs live in the MAC; their sizes are checked here.
   initial begin
      if (TX_CELLS != 24 || RX_CELLS != 68) $error("etd_tx_dma FIFO cell counts unsupported");
   end

   logic dph_wr_r, dph_rd_r, rd_done_r;
   logic [7:0] dph_addr_r;
   logic [31:0] hrdata_r;
   logic pri_rr_r, tx_en_r, sr_pend_r, host_err_r;
   logic [4:0] thresh_r;
   logic [7:0] host_code_r, td_req_r, pend_r;
   logic [31:0] src_low_r, src_high_r;
   logic [31:0] hdp_r [8];
   logic [31:0] cp_r [8];
   etd_td_state_type td_state_r;
   logic [2:0] td_ch_r, rr_last_r;
   logic sel_valid_r;
   logic [2:0] sel_chan_r;
   logic [31:0] sel_ptr_r;
   logic wr_now, srst, arb_any, td_any, td_active, chan_in_flight;
   logic [2:0] arb_chan, td_pick;
   logic [7:0] req;
   logic [31:0] rd_mux;

   assign hresp = 1'b0;
   assign hreadyout = !(dph_rd_r && !rd_done_r);
   assign hrdata = hrdata_r;
   assign wr_now = dph_wr_r;

   // Reads take one wait state so that read data always come from a flop and
   // see a write that finished in the cycle before.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dph_wr_r <= 1'b0;
         dph_rd_r <= 1'b0;
         dph_addr_r <= 8'h00;
      end else if (hreadyout) begin
         dph_wr_r <= hsel && hready && htrans[1] && hwrite;
         dph_rd_r <= hsel && hready && htrans[1] && !hwrite;
         dph_addr_r <= haddr[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_done_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
      end else begin
         rd_done_r <= dph_rd_r && !rd_done_r;
         if (dph_rd_r && !rd_done_r) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (dph_addr_r)
         `ETD_OFF_MAC_CTRL: rd_mux[`ETD_BIT_PRI_TYPE] = pri_rr_r;
         `ETD_OFF_TX_CTRL: rd_mux[`ETD_BIT_TX_EN] = tx_en_r;
         `ETD_OFF_FIFO_CTRL: rd_mux[4:0] = thresh_r;
         `ETD_OFF_SOFT_RESET: rd_mux[`ETD_BIT_SOFT_RESET] = sr_pend_r;
         `ETD_OFF_MAC_STATUS: rd_mux = {23'h000000, host_err_r, host_code_r};
         `ETD_OFF_TX_PEND: rd_mux[7:0] = pend_r;
         `ETD_OFF_SRC_LOW: rd_mux = src_low_r;
         `ETD_OFF_SRC_HIGH: rd_mux[15:0] = src_high_r[15:0];
         default: begin
            if (dph_addr_r[7:5] == 3'(`ETD_OFF_HDP_BASE >> 5)) begin
               rd_mux = hdp_r[dph_addr_r[4:2]];
            end else if (dph_addr_r[7:5] == 3'(`ETD_OFF_CP_BASE >> 5)) begin
               rd_mux = cp_r[dph_addr_r[4:2]];
            end
         end
      endcase
   end

   // Soft reset fires only with no frame in flight or being reported, no grant
   // outstanding and the teardown engine idle, so the configuration bus cannot lock up.
   assign srst = sr_pend_r && !frame_busy && !done_valid && !sel_valid_r && td_state_r == TD_IDLE;
   // Only the MAC side sees this pulse; management and interrupt wrapper logic stay out of it.
   assign mac_sreset = srst;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sr_pend_r <= 1'b0;
      end else if (wr_now && dph_addr_r == `ETD_OFF_SOFT_RESET && hwdata[`ETD_BIT_SOFT_RESET]) begin
         sr_pend_r <= 1'b1;
      end else if (srst) begin
         sr_pend_r <= 1'b0;
      end
   end

   // Configuration registers, all returned to defaults by soft reset.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pri_rr_r <= 1'b0;
         tx_en_r <= 1'b0;
         thresh_r <= `ETD_THRESH_RESET;
         src_low_r <= 32'h0000_0000;
         src_high_r <= 32'h0000_0000;
      end else if (srst) begin
         pri_rr_r <= 1'b0;
         tx_en_r <= 1'b0;
         thresh_r <= `ETD_THRESH_RESET;
         src_low_r <= 32'h0000_0000;
         src_high_r <= 32'h0000_0000;
      end else if (wr_now) begin
         case (dph_addr_r)
            `ETD_OFF_MAC_CTRL: pri_rr_r <= hwdata[`ETD_BIT_PRI_TYPE];
            `ETD_OFF_TX_CTRL: tx_en_r <= hwdata[`ETD_BIT_TX_EN];
            `ETD_OFF_FIFO_CTRL: begin
               // Values above the cell count clamp to it; zero would start on an empty FIFO.
               if (hwdata[31:0] > 32'(TX_CELLS)) begin
                  thresh_r <= 5'(TX_CELLS);
               end else if (hwdata[4:0] != 5'h00) begin
                  thresh_r <= hwdata[4:0];
               end
            end
            `ETD_OFF_SRC_LOW: src_low_r <= hwdata;
            `ETD_OFF_SRC_HIGH: src_high_r <= {16'h0000, hwdata[15:0]};
            default: ;
         endcase
      end
   end
   assign tx_enable = tx_en_r;
   assign src_mac_addr = {src_high_r[15:0], src_low_r};

   // Host error is deliberately outside the soft reset.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         host_err_r <= 1'b0;
         host_code_r <= 8'h00;
      end else if (host_err_valid && !host_err_r) begin
         host_err_r <= 1'b1;
         host_code_r <= host_err_code;
      end
   end
   assign host_error_irq = host_err_r;

   // Teardown requests queue per channel; a new one wins over the pickup clear.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         td_req_r <= 8'h00;
      end else if (srst) begin
         td_req_r <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (wr_now && dph_addr_r == `ETD_OFF_TEARDOWN && hwdata[2:0] == 3'(i)) begin
               td_req_r[i] <= 1'b1;
            end else if (td_state_r == TD_IDLE && td_any && td_pick == 3'(i)) begin
               td_req_r[i] <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      td_any = |td_req_r;
      td_pick = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (td_req_r[i]) begin
            td_pick = 3'(i);
         end
      end
   end
   assign td_active = tx_en_r && hdp_r[td_pick] != 32'h0000_0000;
   // A completion still being reported counts as in flight: its head pointer has not advanced yet.
   assign chan_in_flight = (frame_busy && frame_chan == td_ch_r) || (sel_valid_r && sel_chan_r == td_ch_r)
      || (done_valid && done_chan == td_ch_r);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         td_state_r <= TD_IDLE;
         td_ch_r <= 3'h0;
      end else begin
         unique case (td_state_r)
            TD_IDLE: begin
               if (td_any && !sr_pend_r) begin
                  td_ch_r <= td_pick;
                  td_state_r <= td_active ? TD_DRAIN : TD_FINISH;
               end
            end
            TD_DRAIN: begin
               if (!chan_in_flight) begin
                  td_state_r <= hdp_r[td_ch_r] != 32'h0000_0000 ? TD_FLAG : TD_FINISH;
               end
            end
            TD_FLAG: begin
               if (flag_ready) begin
                  td_state_r <= TD_FINISH;
               end
            end
            TD_FINISH: td_state_r <= TD_IDLE;
         endcase
      end
   end
   assign flag_valid = td_state_r == TD_FLAG;
   assign flag_ptr = hdp_r[td_ch_r];

   // Head pointers: soft reset, teardown clear, completion advance, host write.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 8; i++) hdp_r[i] <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (srst) begin
               hdp_r[i] <= 32'h0000_0000;
            end else if (td_state_r == TD_FINISH && td_ch_r == 3'(i)) begin
               hdp_r[i] <= 32'h0000_0000;
            end else if (done_valid && done_chan == 3'(i)) begin
               hdp_r[i] <= done_next_ptr;
            end else if (wr_now && dph_addr_r == `ETD_OFF_HDP_BASE + 8'(4 * i)) begin
               hdp_r[i] <= hwdata;
            end
         end
      end
   end

   // Completion pointers and per-channel pending; the set wins over the acknowledge.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 8; i++) cp_r[i] <= 32'h0000_0000;
         pend_r <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (srst) begin
               cp_r[i] <= 32'h0000_0000;
               pend_r[i] <= 1'b0;
            end else if (td_state_r == TD_FINISH && td_ch_r == 3'(i)) begin
               cp_r[i] <= `ETD_TD_CP_VALUE;
               pend_r[i] <= 1'b1;
            end else if (done_valid && done_chan == 3'(i)) begin
               cp_r[i] <= done_cp;
               pend_r[i] <= 1'b1;
            end else if (wr_now && dph_addr_r == `ETD_OFF_CP_BASE + 8'(4 * i)) begin
               cp_r[i] <= hwdata;
               if (hwdata == cp_r[i]) begin
                  pend_r[i] <= 1'b0;
               end
            end
         end
      end
   end
   assign tx_irq = pend_r;

   // A channel under teardown leaves arbitration at once.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         req[i] = tx_en_r && hdp_r[i] != 32'h0000_0000 && !td_req_r[i]
            && !(td_state_r != TD_IDLE && td_ch_r == 3'(i));
      end
   end

   etd_arb #(.N(8)) etd_arb_inst (
      .req(req),
      .rr_mode(pri_rr_r),
      .last(rr_last_r),
      .any(arb_any),
      .chan(arb_chan)
   );

   // Grant register: one channel offered to the MAC until it takes it.
   // A completion cycle still shows the old head pointer, so no grant is made in it.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sel_valid_r <= 1'b0;
         sel_chan_r <= 3'h0;
         sel_ptr_r <= 32'h0000_0000;
         rr_last_r <= 3'h7;
      end else if (srst) begin
         sel_valid_r <= 1'b0;
         rr_last_r <= 3'h7;
      end else if (sel_valid_r) begin
         if (sel_ready) begin
            sel_valid_r <= 1'b0;
            rr_last_r <= sel_chan_r;
         end
      end else if (arb_any && !frame_busy && !done_valid && !sr_pend_r) begin
         sel_valid_r <= 1'b1;
         sel_chan_r <= arb_chan;
         sel_ptr_r <= hdp_r[arb_chan];
      end
   end
   assign sel_valid = sel_valid_r;
   assign sel_chan = sel_chan_r;
   assign sel_ptr = sel_ptr_r;

   etd_start_gate #(.CELLS(TX_CELLS)) etd_start_gate_inst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .cells_avail(fifo_cells),
      .pkt_complete(fifo_pkt_complete),
      .thresh(thresh_r),
      .start(wire_start)
   );

   logic arb_load;
   assign arb_load = !sel_valid_r && arb_any && !frame_busy && !done_valid && !sr_pend_r && !srst;

   AST_FIXED_TOP: assert property (@(posedge clk_sys) disable iff (!resetn)
      arb_load && !pri_rr_r |=> sel_valid_r && ($past(req) & ~(8'hff >> (3'h7 - sel_chan_r))) == 8'h00)
      else $error("fixed mode skipped a higher channel");
   AST_RR_NEXT: assert property (@(posedge clk_sys) disable iff (!resetn)
      arb_load && pri_rr_r && req[3'(rr_last_r + 3'h1)] |=> sel_chan_r == $past(rr_last_r) + 3'h1)
      else $error("round robin did not take the next channel");
   AST_REQ_ONLY_ACTIVE: assert property (@(posedge clk_sys) disable iff (!resetn)
      arb_load |-> tx_en_r && hdp_r[arb_chan] != 32'h0000_0000)
      else $error("idle channel was granted");
   AST_TD_NO_ABORT: assert property (@(posedge clk_sys) disable iff (!resetn)
      td_state_r == TD_DRAIN && chan_in_flight |=> td_state_r == TD_DRAIN)
      else $error("teardown left drain with frame in flight");
   AST_TD_CLEAR_CP: assert property (@(posedge clk_sys) disable iff (!resetn)
      td_state_r == TD_FINISH && !srst |=> hdp_r[$past(td_ch_r)] == 32'h0000_0000
         && cp_r[$past(td_ch_r)] == `ETD_TD_CP_VALUE && tx_irq[$past(td_ch_r)])
      else $error("teardown finish did not clear head or set pointer");
   AST_TD_EN_KEPT: assert property (@(posedge clk_sys) disable iff (!resetn)
      td_state_r == TD_FINISH && !wr_now && !srst |=> $stable(tx_en_r))
      else $error("teardown changed transmit enable");
   AST_TD_INACTIVE: assert property (@(posedge clk_sys) disable iff (!resetn)
      td_state_r == TD_IDLE && td_any && !sr_pend_r && !td_active |=> td_state_r == TD_FINISH ##1 !flag_valid)
      else $error("inactive teardown touched a descriptor");
   AST_SR_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
      mac_sreset |-> !frame_busy && td_state_r == TD_IDLE && !sel_valid_r)
      else $error("soft reset while busy");
   AST_SR_BIT: assert property (@(posedge clk_sys) disable iff (!resetn)
      sr_pend_r && !srst |=> sr_pend_r)
      else $error("soft reset bit dropped early");
   AST_HOST_ERR: assert property (@(posedge clk_sys) disable iff (!resetn)
      host_error_irq |=> host_error_irq && $stable(host_code_r))
      else $error("host error cleared without hardware reset");
   AST_THRESH: assert property (@(posedge clk_sys) disable iff (!resetn)
      thresh_r <= 5'(TX_CELLS) && thresh_r != 5'h00)
      else $error("cell threshold out of range");

   COV_TD_FLAG: cover property (@(posedge clk_sys) disable iff (!resetn)
      flag_valid && flag_ready);
   COV_RR_WRAP: cover property (@(posedge clk_sys) disable iff (!resetn)
      sel_valid_r && sel_ready && pri_rr_r && sel_chan_r == 3'h0 && rr_last_r == 3'h7);
   COV_SRST: cover property (@(posedge clk_sys) disable iff (!resetn)
      sr_pend_r ##1 mac_sreset);
endmodule
`default_nettype wire

// ==== verification/etd_mac_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Transmit path stand-in: takes one grant at a time, sends a frame of twenty cycles, then reports completion.
module etd_mac_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sel_valid,
   input wire logic [2:0] sel_chan,
   input wire logic [31:0] sel_ptr,
   output logic sel_ready,
   output logic frame_busy,
   output logic [2:0] frame_chan,
   output logic done_valid,
   output logic [2:0] done_chan,
   output logic [31:0] done_next_ptr,
   output logic [31:0] done_cp,
   input wire logic flag_valid,
   input wire logic [31:0] flag_ptr,
   output logic flag_ready,
   output logic [31:0] last_flag
);
   logic [4:0] cnt_r;
   logic [31:0] ptr_r;
   assign sel_ready = !frame_busy && !done_valid;
   assign done_chan = done_valid ? frame_chan : ~frame_chan;
   // Outside the pulse the completion fields show garbage, so the design must qualify them.
   assign done_cp = done_valid ? ptr_r : ~ptr_r;
   // A descriptor with bit 8 set has one successor, so a teardown finds a further start of packet.
   assign done_next_ptr = !done_valid ? ~ptr_r : (ptr_r[8] ? ptr_r + 32'h0000_0100 : 32'h0000_0000);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         frame_busy <= 1'b0;
         done_valid <= 1'b0;
         cnt_r <= 5'h00;
         ptr_r <= 32'h0000_0000;
         frame_chan <= 3'h0;
      end else begin
         done_valid <= frame_busy && cnt_r == 5'h00;
         if (sel_valid && sel_ready) begin
            frame_busy <= 1'b1;
            cnt_r <= 5'h13;
            ptr_r <= sel_ptr;
            frame_chan <= sel_chan;
         end else if (frame_busy) begin
            if (cnt_r == 5'h00) begin
               frame_busy <= 1'b0;
            end
            cnt_r <= cnt_r - 5'h01;
         end
      end
   end
   // The flag write is answered a cycle late, as a slow memory would.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flag_ready <= 1'b0;
         last_flag <= 32'h0000_0000;
      end else begin
         flag_ready <= flag_valid && !flag_ready;
         if (flag_valid && flag_ready) begin
            last_flag <= flag_ptr;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/etd_tx_dma_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "etd_consts.svh"
module etd_tx_dma_tb;
   logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp, sel_valid, sel_ready, frame_busy, done_valid;
   logic flag_valid, flag_ready, fifo_pkt_complete, wire_start, host_err_valid, host_error_irq, mac_sreset, tx_enable;
   logic [31:0] haddr, hwdata, hrdata, sel_ptr, done_next_ptr, done_cp, flag_ptr, last_flag, q;
   logic [1:0] htrans;
   logic [2:0] sel_chan, frame_chan, done_chan;
   logic [4:0] fifo_cells;
   logic [7:0] host_err_code, tx_irq;
   logic [47:0] src_mac_addr;
   int miscompares, n_compared, n_done, n_flag, n_sreset;
   logic [2:0] grants[$];
   etd_tx_dma etd_tx_dma_inst (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sel_valid, .sel_chan, .sel_ptr, .sel_ready, .frame_busy,
      .frame_chan, .done_valid, .done_chan, .done_next_ptr, .done_cp, .flag_valid, .flag_ptr, .flag_ready,
      .fifo_cells, .fifo_pkt_complete, .wire_start, .host_err_valid, .host_err_code, .tx_irq, .host_error_irq,
      .mac_sreset, .tx_enable, .src_mac_addr);
   etd_mac_model etd_mac_model_inst (.clk_sys, .resetn, .sel_valid, .sel_chan, .sel_ptr, .sel_ready, .frame_busy,
      .frame_chan, .done_valid, .done_chan, .done_next_ptr, .done_cp, .flag_valid, .flag_ptr, .flag_ready,
      .last_flag);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (sel_valid && sel_ready) grants.push_back(sel_chan);
      if (done_valid) n_done++;
      if (flag_valid && flag_ready) n_flag++;
      if (mac_sreset) begin
         n_sreset++;
         chk({29'h0, frame_busy, done_valid, sel_valid}, 32'h0);
      end
   end
   task automatic print_verdict();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Samples hready on the falling edge, which shows the level that the next rising edge will see.
   task automatic ph(output logic [31:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (hreadyout !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 50) begin
         miscompares++;
         print_verdict();
      end
      d = hrdata;
      @(posedge clk_sys);
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      ph(q);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      ph(q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xf(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xf(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   function automatic logic cond(input int what, input int arg);
      case (what)
         0: return n_done >= arg;
         1: return tx_irq[arg] === 1'b1;
         2: return frame_busy === 1'b1;
         3: return n_flag >= arg;
         default: return n_sreset >= arg;
      endcase
   endfunction
   task automatic wt(input int what, input int arg);
      int n;
      n = 0;
      while (n < 2000 && !cond(what, arg)) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 2000) begin
         miscompares++;
         print_verdict();
      end
      @(posedge clk_sys);
   endtask
   // Queues three channels with transmit off so that all of them compete at once.
   task automatic run3(input logic m, input logic [2:0] c[3], input logic [2:0] e[3]);
      int b;
      logic [31:0] mask;
      b = grants.size();
      mask = 32'h0;
      wr(`ETD_OFF_TX_CTRL, 32'h0);
      wr(`ETD_OFF_MAC_CTRL, {31'h0, m});
      for (int i = 0; i < 3; i++) wr(`ETD_OFF_HDP_BASE + 8'(4 * c[i]), 32'h1000 + 32'(16 * c[i]));
      repeat (3) @(posedge clk_sys);
      chk(32'(grants.size() - b), 32'h0);
      wr(`ETD_OFF_TX_CTRL, 32'h1);
      wt(0, n_done + 3);
      for (int i = 0; i < 3; i++) begin
         chk({29'h0, grants[b + i]}, {29'h0, e[i]});
         mask = mask | (32'h1 << e[i]);
      end
      rd(`ETD_OFF_TX_PEND, mask);
      for (int i = 0; i < 3; i++) begin
         rd(`ETD_OFF_CP_BASE + 8'(4 * e[i]), 32'h1000 + 32'(16 * e[i]));
         wr(`ETD_OFF_CP_BASE + 8'(4 * e[i]), 32'h1000 + 32'(16 * e[i]));
      end
      rd(`ETD_OFF_TX_PEND, 32'h0);
   endtask
   initial begin
      int b;
      {resetn, hsel, hwrite, htrans, haddr, hwdata, fifo_cells, fifo_pkt_complete} = '0;
      {host_err_valid, host_err_code} = '0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rd(`ETD_OFF_FIFO_CTRL, 32'h18);
      rd(`ETD_OFF_SOFT_RESET, 32'h0);
      rd(8'h3c, 32'h0);
      wr(`ETD_OFF_SRC_LOW, 32'h3344_5566);
      wr(`ETD_OFF_SRC_HIGH, 32'h0000_1122);
      for (int i = 0; i < 8; i++) wr(`ETD_OFF_HDP_BASE + 8'(4 * i), 32'h0);
      chk(src_mac_addr[47:16], 32'h1122_3344);
      wr(`ETD_OFF_FIFO_CTRL, 32'h1e);
      rd(`ETD_OFF_FIFO_CTRL, 32'h18);
      wr(`ETD_OFF_FIFO_CTRL, 32'h0);
      rd(`ETD_OFF_FIFO_CTRL, 32'h18);
      wr(`ETD_OFF_FIFO_CTRL, 32'h4);
      for (int i = 0; i < 4; i++) begin
         fifo_cells <= (i < 3) ? 5'(3 + i) : 5'h0;
         fifo_pkt_complete <= (i == 3);
         repeat (3) @(posedge clk_sys);
         chk({31'h0, wire_start}, {31'h0, i > 0});
      end
      run3(1'b1, '{3'd2, 3'd4, 3'd6}, '{3'd2, 3'd4, 3'd6});
      run3(1'b0, '{3'd1, 3'd5, 3'd7}, '{3'd7, 3'd5, 3'd1});
      wr(`ETD_OFF_TEARDOWN, 32'h3);
      wt(1, 3);
      rd(`ETD_OFF_CP_BASE + 8'hc, `ETD_TD_CP_VALUE);
      rd(`ETD_OFF_HDP_BASE + 8'hc, 32'h0);
      rd(`ETD_OFF_TX_CTRL, 32'h1);
      chk({31'h0, tx_enable}, 32'h1);
      chk(32'(n_flag), 32'h0);
      wr(`ETD_OFF_CP_BASE + 8'hc, `ETD_TD_CP_VALUE);
      rd(`ETD_OFF_TX_PEND, 32'h0);
      b = n_done;
      wr(`ETD_OFF_HDP_BASE + 8'h14, 32'h2100);
      wt(2, 0);
      wr(`ETD_OFF_TEARDOWN, 32'h5);
      wt(3, 1);
      chk(32'(n_done - b), 32'h1);
      chk(last_flag, 32'h2200);
      rd(`ETD_OFF_HDP_BASE + 8'h14, 32'h0);
      rd(`ETD_OFF_CP_BASE + 8'h14, `ETD_TD_CP_VALUE);
      wr(`ETD_OFF_CP_BASE + 8'h14, `ETD_TD_CP_VALUE);
      host_err_code <= 8'h5a;
      host_err_valid <= 1'b1;
      @(posedge clk_sys);
      host_err_valid <= 1'b0;
      wr(`ETD_OFF_HDP_BASE + 8'h8, 32'h1020);
      wt(2, 0);
      wr(`ETD_OFF_SOFT_RESET, 32'h1);
      rd(`ETD_OFF_SOFT_RESET, 32'h1);
      wt(4, 1);
      rd(`ETD_OFF_SOFT_RESET, 32'h0);
      rd(`ETD_OFF_FIFO_CTRL, 32'h18);
      rd(`ETD_OFF_TX_CTRL, 32'h0);
      chk({30'h0, hresp, tx_enable}, 32'h0);
      rd(`ETD_OFF_MAC_STATUS, 32'h15a);
      chk({31'h0, host_error_irq}, 32'h1);
      print_verdict();
   end
endmodule
`default_nettype wire
